// >>> shared/sbs_pkg.sv
`default_nettype none
package sbs_pkg;
  localparam int DATA_W_DEFAULT = 36;
  localparam int ADDR_W_DEFAULT = 19;
  localparam int BYTE_BITS      = 8;
  localparam int BURST_BITS     = 2;
  localparam logic [1:0] BURST_ZERO  = 2'h0;
  localparam logic [1:0] BURST_STEP  = 2'h1;
  localparam logic       DRIVE_RESET = 1'h0;
  typedef enum logic [1:0] {
    SBS_IDLE,
    SBS_ACTIVE,
    SBS_POWERDOWN
  } sbs_state_e;
endpackage : sbs_pkg
`default_nettype wire

// >>> logic/sbs_control.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_control #(
  parameter int DATA_W = sbs_pkg::DATA_W_DEFAULT,
  parameter int ADDR_W = sbs_pkg::ADDR_W_DEFAULT
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [ADDR_W-1:0]         address,
  input  wire logic                      lane_a_write_n,
  input  wire logic                      lane_b_write_n,
  input  wire logic                      lane_c_write_n,
  input  wire logic                      lane_d_write_n,
  input  wire logic                      partial_write_permit_n,
  input  wire logic                      full_word_write_n,
  input  wire logic                      chip_enable_n,
  input  wire logic                      secondary_select_low_n,
  input  wire logic                      secondary_select_high,
  input  wire logic                      processor_addr_strobe_n,
  input  wire logic                      controller_addr_strobe_n,
  input  wire logic                      burst_advance_n,
  input  wire logic                      linear_order_n,
  input  wire logic                      snooze_request,
  input  wire logic                      output_enable_n,
  input  wire logic [(DATA_W == 18 ? 16 : 32)-1:0] data_lane_in,
  output logic      [(DATA_W == 18 ? 16 : 32)-1:0] data_lane_out,
  output logic      [(DATA_W == 18 ? 16 : 32)-1:0] data_lane_oe,
  input  wire logic [(DATA_W == 18 ? 2 : 4)-1:0]   parity_lane_in,
  output logic      [(DATA_W == 18 ? 2 : 4)-1:0]   parity_lane_out,
  output logic      [(DATA_W == 18 ? 2 : 4)-1:0]   parity_lane_oe,
  output logic                           snooze_standby,
  output logic                           power_down
);
  localparam int LANES  = (DATA_W == 18) ? 2 : 4;
  // parity only on 18 and 36
  localparam bit PARITY = (DATA_W != 32);
  localparam int LANE_W = PARITY ? 9 : 8;
  localparam int WORD_W = LANES * LANE_W;
  localparam int BB     = sbs_pkg::BURST_BITS;

  logic [WORD_W-1:0]  mem [2**ADDR_W];
  sbs_pkg::sbs_state_e state;
  logic [ADDR_W-1:0]  base_addr;
  logic [BB-1:0]      burst_cnt;
  logic               linear_mode;
  logic [ADDR_W-1:0]  rd_addr;
  logic               rd_pend;
  logic               drive_q;
  logic [WORD_W-1:0]  rd_word;

  logic [ADDR_W-1:0]  next_addr;
  logic [ADDR_W-1:0]  acc_addr;
  logic [BB-1:0]      next_cnt;
  logic               p_load;
  logic               c_load;
  logic               sel_ok;
  logic               do_write;
  logic               do_read;
  logic [LANES-1:0]   wmask;
  logic [WORD_W-1:0]  wdata;
  logic [3:0]         lanes_low;

  function automatic logic [BB-1:0] burst_low(input logic [BB-1:0] base, input logic [BB-1:0] cnt,
                                              input logic lin);
    if (lin) begin
      burst_low = base + cnt;
    end else begin
      burst_low = base ^ cnt;
    end
  endfunction : burst_low

  function automatic logic [ADDR_W-1:0] with_low(input logic [ADDR_W-1:0] a, input logic [BB-1:0] low);
    logic [ADDR_W-1:0] r;
    r = a;
    r[BB-1:0] = low;
    with_low = r;
  endfunction : with_low

  assign lanes_low = {~lane_d_write_n, ~lane_c_write_n, ~lane_b_write_n, ~lane_a_write_n};

  always_comb begin
    // processor strobe qualified by chip enable
    p_load = ~snooze_request & ~processor_addr_strobe_n & ~chip_enable_n;
    c_load = ~snooze_request & ~controller_addr_strobe_n & ~p_load;
    // chip enables sampled only on a load
    sel_ok = ~chip_enable_n & ~secondary_select_low_n & secondary_select_high;
    next_cnt = burst_cnt;
    next_addr = base_addr;
    acc_addr = with_low(base_addr, burst_low(base_addr[BB-1:0], burst_cnt, linear_mode));
    if (~full_word_write_n) begin
      wmask = '1;
    end else if (~partial_write_permit_n) begin
      wmask = lanes_low[LANES-1:0];
    end else begin
      wmask = '0;
    end
    do_write = 1'b0;
    do_read  = 1'b0;
    if (p_load) begin
      next_addr = address;
      next_cnt  = sbs_pkg::BURST_ZERO;
      acc_addr  = address;
      do_read   = sel_ok;
    end else if (c_load) begin
      next_addr = address;
      next_cnt  = sbs_pkg::BURST_ZERO;
      acc_addr  = address;
      do_write  = sel_ok & (~full_word_write_n | ~partial_write_permit_n);
      do_read   = sel_ok & ~do_write;
    end else if (~snooze_request && state == sbs_pkg::SBS_ACTIVE) begin
      if (~burst_advance_n) begin
        next_cnt = burst_cnt + sbs_pkg::BURST_STEP;
      end
      acc_addr = with_low(base_addr, burst_low(base_addr[BB-1:0], next_cnt, linear_mode));
      do_write = ~full_word_write_n | ~partial_write_permit_n;
      do_read  = ~do_write;
    end
  end

  // write data lanes regrouped with parity
  always_comb begin
    wdata = '0;
    for (int i = 0; i < LANES; i++) begin
      wdata[i*LANE_W +: 8] = data_lane_in[i*8 +: 8];
      if (PARITY) begin
        wdata[i*LANE_W + LANE_W - 1] = parity_lane_in[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state     <= sbs_pkg::SBS_IDLE;
      base_addr <= '0;
      burst_cnt <= sbs_pkg::BURST_ZERO;
    end else if (~snooze_request) begin
      base_addr <= next_addr;
      burst_cnt <= next_cnt;
      if (p_load || c_load) begin
        if (p_load ? sel_ok : (sel_ok)) begin
          state <= sbs_pkg::SBS_ACTIVE;
        end else begin
          state <= sbs_pkg::SBS_POWERDOWN;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      linear_mode <= 1'b0;
    end else if (~snooze_request) begin
      linear_mode <= ~linear_order_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (~rst && do_write) begin
      for (int i = 0; i < LANES; i++) begin
        if (wmask[i]) begin
          mem[acc_addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_pend <= do_read;
      rd_addr <= acc_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_word <= mem[rd_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (rst || snooze_request) begin
      drive_q <= sbs_pkg::DRIVE_RESET;
    end else begin
      drive_q <= rd_pend;
    end
  end

  always_comb begin
    data_lane_out   = '0;
    parity_lane_out = '0;
    for (int i = 0; i < LANES; i++) begin
      data_lane_out[i*8 +: 8] = rd_word[i*LANE_W +: 8];
      if (PARITY) begin
        parity_lane_out[i] = rd_word[i*LANE_W + LANE_W - 1];
      end
    end
  end

  assign data_lane_oe   = {(LANES*8){drive_q & ~output_enable_n}};
  assign parity_lane_oe = PARITY ? {LANES{drive_q & ~output_enable_n}} : '0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snooze_standby <= 1'b0;
      power_down     <= 1'b0;
    end else begin
      snooze_standby <= snooze_request;
      power_down     <= (state == sbs_pkg::SBS_POWERDOWN);
    end
  end
endmodule : sbs_control
`default_nettype wire

// >>> verification/sbs_control_props.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_control_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        chip_enable_n,
  input wire logic        secondary_select_low_n,
  input wire logic        secondary_select_high,
  input wire logic        processor_addr_strobe_n,
  input wire logic        controller_addr_strobe_n,
  input wire logic        full_word_write_n,
  input wire logic        partial_write_permit_n,
  input wire logic        snooze_request,
  input wire logic        output_enable_n,
  input wire logic [31:0] data_lane_oe,
  input wire logic        snooze_standby,
  input wire logic        power_down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence rd_load;
    !snooze_request && !controller_addr_strobe_n && processor_addr_strobe_n && !chip_enable_n &&
      !secondary_select_low_n && secondary_select_high && full_word_write_n && partial_write_permit_n;
  endsequence
  sequence calm_path;
    !snooze_request ##1 !output_enable_n;
  endsequence
  a_read_pipe: assert property (rd_load ##1 calm_path |-> &data_lane_oe)
    else $error("read not driven");
  a_oe_async: assert property (output_enable_n |-> data_lane_oe == '0)
    else $error("drive while disabled");
  a_snooze_enter: assert property (snooze_request |=> snooze_standby)
    else $error("no standby");
  a_snooze_quiet: assert property (snooze_request |=> data_lane_oe == '0)
    else $error("drive in standby");
  a_desel_down: assert property (!snooze_request && processor_addr_strobe_n && !controller_addr_strobe_n &&
    chip_enable_n |-> ##2 power_down)
    else $error("no power down");
  a_proc_sec_down: assert property (!snooze_request && !processor_addr_strobe_n && !chip_enable_n &&
    !secondary_select_high |-> ##2 power_down)
    else $error("no power down");
  a_proc_ignored: assert property (!snooze_request && !processor_addr_strobe_n && chip_enable_n &&
    controller_addr_strobe_n |-> ##2 $stable(power_down))
    else $error("strobe not ignored");
  a_hold_awake: assert property ((processor_addr_strobe_n && controller_addr_strobe_n) ##1
    !power_down |=> !power_down)
    else $error("power down without load");
endmodule : sbs_control_props
bind sbs_control sbs_control_props i_props (.clk_sys, .rst, .chip_enable_n, .secondary_select_low_n,
  .secondary_select_high, .processor_addr_strobe_n, .controller_addr_strobe_n, .full_word_write_n,
  .partial_write_permit_n, .snooze_request, .output_enable_n, .data_lane_oe, .snooze_standby, .power_down);
`default_nettype wire

// >>> verification/sbs_host.sv
`timescale 1ns/10ps
`default_nettype none
module sbs_host #(
  parameter int ADDR_W = 6
) (
  input  wire logic         clk_sys,
  output logic [ADDR_W-1:0] address,
  output logic [9:0]        ctl,
  output logic [35:0]       dq
);
  task automatic op(input logic [9:0] c, input logic [ADDR_W-1:0] a, input logic [35:0] d);
    ctl = c;
    address = a;
    dq = d;
    @(negedge clk_sys);
  endtask : op
  initial begin
    ctl = 10'h3ff;
    address = '0;
    dq = '0;
  end
endmodule : sbs_host
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int AW = 6;
  logic          clk_sys = 1'h0, rst = 1'h1, sel_high = 1'h1, snooze = 1'h0, oe_n = 1'h0, order_n = 1'h0;
  logic [AW-1:0] address;
  logic [9:0]    ctl;
  logic [35:0]   dq, mem [64], q [$];
  logic [31:0]   dout, d_oe;
  logic [3:0]    pout, p_oe;
  int            n_fail = 0, total_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  sbs_host #(.ADDR_W(AW)) i_host (.clk_sys, .address, .ctl, .dq);
  sbs_control #(.DATA_W(36), .ADDR_W(AW)) i_dut (.clk_sys, .rst, .address, .lane_a_write_n(ctl[0]),
    .lane_b_write_n(ctl[1]), .lane_c_write_n(ctl[2]), .lane_d_write_n(ctl[3]), .partial_write_permit_n(ctl[4]),
    .full_word_write_n(ctl[5]), .chip_enable_n(ctl[6]), .controller_addr_strobe_n(ctl[7]),
    .processor_addr_strobe_n(ctl[8]), .burst_advance_n(ctl[9]), .secondary_select_low_n(1'h0),
    .secondary_select_high(sel_high), .linear_order_n(order_n), .snooze_request(snooze), .output_enable_n(oe_n),
    .data_lane_in(dq[31:0]), .data_lane_out(dout), .data_lane_oe(d_oe), .parity_lane_in(dq[35:32]),
    .parity_lane_out(pout), .parity_lane_oe(p_oe), .snooze_standby(), .power_down());
  function automatic logic [35:0] rnd();
    return 36'({$urandom(), $urandom()});
  endfunction : rnd
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic idle(input int n);
    // deselect first so wait cycles stop re-reading
    i_host.op(10'h37f, AW'($urandom()), ~dq);
    repeat (n - 1) i_host.op(10'h3ff, AW'($urandom()), ~dq);
  endtask : idle
  // w is processor strobe, full write, permit, lanes
  task automatic acc(input logic [AW-1:0] a, input logic [6:0] w);
    logic [35:0] d;
    d = rnd();
    i_host.op({1'h1, w[6], ~w[6], 1'h0, w[5:0]}, a, d);
    if (!w[6] || (w[5] && w[4])) q.push_back(mem[a]);
    else for (int i = 0; i < 4; i++) if (!w[5] || (!w[4] && !w[i])) begin
      mem[a][8*i+:8] = d[8*i+:8];
      mem[a][32+i] = d[32+i];
    end
  endtask : acc
  task automatic burst(input logic [AW-1:0] b);
    acc(b, 7'h7f);
    sel_high = 1'h0;
    for (int k = 1; k < 4; k++) begin
      i_host.op(10'h1ff, AW'($urandom()), ~dq);
      q.push_back(mem[{b[AW-1:2], order_n ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)}]);
    end
    sel_high = 1'h1;
  endtask : burst
  always @(posedge clk_sys) begin
    #2;
    cyc++;
    if (cyc > 2000) begin
      n_fail++;
      final_report();
    end
    if (!rst && (d_oe !== '0 || p_oe !== '0)) begin
      chk("drive", '1, {p_oe, d_oe});
      chk("read data", q.size() > 0 ? q.pop_front() : 'x, {pout, dout});
    end
  end
  initial begin
    void'($urandom(79039));
    repeat (6) @(negedge clk_sys);
    rst = 1'h0;
    for (int a = 0; a < 8; a++) acc(AW'(a), 7'h5f);
    for (int a = 0; a < 8; a++) acc(AW'(a), 7'h7f);
    idle(4);
    $display("test full write done");
    for (int a = 0; a < 8; a++) acc(AW'(a), {2'h3, 1'($urandom()), 4'($urandom())});
    for (int a = 0; a < 8; a++) acc(AW'(a), 7'h7f);
    idle(4);
    $display("test lane write done");
    sel_high = 1'h0;
    i_host.op(10'h2bf, '0, ~dq);
    sel_high = 1'h1;
    i_host.op(10'h2df, 6'h1, rnd());
    i_host.op(10'h35f, 6'h2, rnd());
    acc(6'h3, 7'h1f);
    idle(3);
    snooze = 1'h1;
    i_host.op(10'h31f, 6'h4, rnd());
    snooze = 1'h0;
    oe_n = 1'h1;
    i_host.op(10'h33f, 6'h5, ~dq);
    idle(3);
    oe_n = 1'h0;
    for (int a = 1; a < 5; a++) acc(AW'(a), 7'h7f);
    idle(4);
    $display("test select and snooze done");
    for (int m = 0; m < 2; m++) begin
      order_n = 1'(m);
      burst(AW'(m * 2 + 5));
      idle(4);
    end
    $display("test burst done");
    chk("queue left", '0, 36'(q.size()));
    final_report();
  end
endmodule : tb
`default_nettype wire
